// *** dtid_cond_eval.sv ***
// Condition test for the conditional branch.
// Assumes flags and condition code come from logic on the same clock.
module dtid_cond_eval (
  input  wire dtid_pkg::dtid_ccr_t ccr_i,
  input  wire logic [3:0]          cc_i,
  output logic                     taken_o
);
  import dtid_pkg::*;

  always_comb begin
    case (cc_i)
      4'h0:    taken_o = 1'b1;
      4'h1:    taken_o = 1'b0;
      4'h2:    taken_o = !(ccr_i.c || ccr_i.z);
      4'h3:    taken_o = ccr_i.c || ccr_i.z;
      4'h4:    taken_o = !ccr_i.c;
      4'h5:    taken_o = ccr_i.c;
      4'h6:    taken_o = !ccr_i.z;
      4'h7:    taken_o = ccr_i.z;
      4'h8:    taken_o = !ccr_i.v;
      4'h9:    taken_o = ccr_i.v;
      4'ha:    taken_o = !ccr_i.n;
      4'hb:    taken_o = ccr_i.n;
      4'hc:    taken_o = ccr_i.n == ccr_i.v;
      4'hd:    taken_o = ccr_i.n != ccr_i.v;
      4'he:    taken_o = !ccr_i.z && (ccr_i.n == ccr_i.v);
      default: taken_o = ccr_i.z || (ccr_i.n != ccr_i.v);
    endcase
  end
endmodule : dtid_cond_eval

// *** dtid_defs.svh ***
// Constants for the data transfer decode and execute block.
// Assumes inclusion by bare name from the package and the design files.
`ifndef DTID_DEFS_SVH
`define DTID_DEFS_SVH

`define DTID_OP_W         6
`define DTID_OP_MOVE      6'h00
`define DTID_OP_ARITH     6'h01
`define DTID_OP_LOGIC     6'h0f
`define DTID_OP_SHIFT     6'h13
`define DTID_OP_BIT       6'h1b
`define DTID_OP_BRANCH    6'h29
`define DTID_OP_BCC       6'h29
`define DTID_OP_SYSTEM    6'h2e
`define DTID_OP_BLOCK     6'h36
`define DTID_OP_COUNT     6'h37

`define DTID_NUM_REGS     8
`define DTID_STEP_BYTE    16'h0001
`define DTID_STEP_WORD    16'h0002
`define DTID_SHORT_HI     8'hff
`define DTID_REG_RST      16'h0000
`define DTID_CCR_RST      4'h0
`define DTID_BYTE_PAD     8'h00

`endif

// *** dtid_mem_model.sv ***
// Data memory model for the transfer block, answering each request lat_i + 1 cycles after it is raised.
// Assumes one clock and a request held until its acknowledge.
module dtid_mem_model (
  input  wire logic        clk_i,
  input  wire logic        nrst_i,
  input  wire logic [1:0]  lat_i,
  input  wire logic        req_i,
  input  wire logic        we_i,
  input  wire logic        byte_i,
  input  wire logic [15:0] addr_i,
  input  wire logic [15:0] wdata_i,
  output logic             ack_o,
  output logic [15:0]      rdata_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [logic [15:0]];
  logic [1:0] cnt;
  function automatic logic [7:0] rd(input logic [15:0] a);
    return mem.exists(a) ? mem[a] : 8'h00;
  endfunction : rd
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ack_o <= 1'b0;
      cnt <= 2'h0;
      rdata_o <= 16'h5a5a;
    end else begin
      ack_o <= 1'b0;
      // Read data is only valid with ack, so it toggles in between
      rdata_o <= ~rdata_o;
      if (req_i && !ack_o) begin
        cnt <= cnt + 2'h1;
        if (cnt == lat_i) begin
          cnt <= 2'h0;
          ack_o <= 1'b1;
          if (we_i && byte_i) mem[addr_i] = wdata_i[7:0];
          if (we_i && !byte_i) mem[addr_i] = wdata_i[15:8];
          if (we_i && !byte_i) mem[addr_i + 16'h1] = wdata_i[7:0];
          if (!we_i) rdata_o <= byte_i ? {~rd(addr_i), rd(addr_i)}
                                       : {rd(addr_i), rd(addr_i + 16'h1)};
        end
      end
    end
  end
endmodule : dtid_mem_model

// *** dtid_pkg.sv ***
// Types shared by the data transfer decode block and its condition evaluator.
// Assumes dtid_defs.svh is on the include path.
package dtid_pkg;
  `include "dtid_defs.svh"

  typedef enum logic [2:0] {
    DTID_M_REG     = 3'h0,
    DTID_M_IND     = 3'h1,
    DTID_M_DISP    = 3'h2,
    DTID_M_POSTINC = 3'h3,
    DTID_M_PREDEC  = 3'h4,
    DTID_M_ABS8    = 3'h5,
    DTID_M_ABS16   = 3'h6,
    DTID_M_IMM     = 3'h7
  } dtid_mode_t;

  typedef enum logic [2:0] {
    DTID_G_TRANSFER = 3'h0,
    DTID_G_ARITH    = 3'h1,
    DTID_G_LOGIC    = 3'h2,
    DTID_G_SHIFT    = 3'h3,
    DTID_G_BIT      = 3'h4,
    DTID_G_BRANCH   = 3'h5,
    DTID_G_SYSTEM   = 3'h6,
    DTID_G_BLOCK    = 3'h7
  } dtid_group_t;

  typedef enum logic [1:0] {
    DTID_S_IDLE = 2'h0,
    DTID_S_MEM  = 2'h1
  } dtid_state_t;

  typedef struct packed {
    logic n;
    logic z;
    logic v;
    logic c;
  } dtid_ccr_t;

  typedef struct packed {
    logic [`DTID_OP_W-1:0] op;
    logic [3:0]            cc;
    logic                  word;
    logic                  store;
    dtid_mode_t            mode;
    logic [2:0]            rn;
    logic [2:0]            rm;
    logic [15:0]           ext;
  } dtid_insn_t;
endpackage : dtid_pkg

// *** dtid_top.sv ***
// Decode and execute of the data transfer group, plus branch test and group tag.
// Assumes a predecoded instruction from fetch and a same-clock data memory with ack.
// Operation
// - 55 instructions in eight functional groups
// - Push: predecrement stack, store word register
// - Pop: load word at stack, postincrement
// - Push and pop share word move encodings
// - Move register, memory, immediate; byte or word
// - Word moves accept the seven listed modes
// - Short absolute mode for byte moves only
// - Branch condition field selects flag test
// - Flags negative, zero, overflow, carry kept
// - Odd word address forced to even
// - Short absolute upper byte all ones
// - Postincrement adds one or two after access
// - Predecrement subtracts one or two, kept
`include "dtid_defs.svh"
module dtid_top #(
  parameter int unsigned SP_INDEX = 7
) (
  input  wire logic                 CLK_SYS_I,
  input  wire logic                 NRST_I,
  input  wire logic                 INSN_VALID_I,
  input  wire dtid_pkg::dtid_insn_t INSN_I,
  output logic                      INSN_READY_O,
  output logic                      MEM_REQ_O,
  output logic                      MEM_WE_O,
  output logic                      MEM_BYTE_O,
  output logic [15:0]               MEM_ADDR_O,
  output logic [15:0]               MEM_WDATA_O,
  input  wire logic                 MEM_ACK_I,
  input  wire logic [15:0]          MEM_RDATA_I,
  output logic                      DONE_O,
  output logic                      ILLEGAL_O,
  output logic                      BRANCH_TAKEN_O,
  output dtid_pkg::dtid_group_t     GROUP_O,
  output dtid_pkg::dtid_ccr_t       CCR_O,
  output logic [15:0]               SP_O
);
  import dtid_pkg::*;

  if (SP_INDEX >= `DTID_NUM_REGS) begin : g_bad_sp
    $error("SP_INDEX must select one of the general registers");
  end

  dtid_state_t state_r;
  dtid_insn_t  cur_r;
  dtid_ccr_t   ccr_r;
  logic [15:0] regs_r [`DTID_NUM_REGS];
  logic [15:0] ptr_r;
  logic        accept;
  logic        is_move;
  logic        legal;
  logic        mem_mode;
  logic        cond_true;
  logic [15:0] step;
  logic [15:0] base;
  logic [15:0] ea;
  logic [15:0] ea_bus;
  logic [15:0] load_val;

  function automatic dtid_group_t group_of(input logic [`DTID_OP_W-1:0] op);
    if (op >= `DTID_OP_BLOCK) begin
      return DTID_G_BLOCK;
    end else if (op >= `DTID_OP_SYSTEM) begin
      return DTID_G_SYSTEM;
    end else if (op >= `DTID_OP_BRANCH) begin
      return DTID_G_BRANCH;
    end else if (op >= `DTID_OP_BIT) begin
      return DTID_G_BIT;
    end else if (op >= `DTID_OP_SHIFT) begin
      return DTID_G_SHIFT;
    end else if (op >= `DTID_OP_LOGIC) begin
      return DTID_G_LOGIC;
    end else if (op >= `DTID_OP_ARITH) begin
      return DTID_G_ARITH;
    end
    return DTID_G_TRANSFER;
  endfunction : group_of

  // Flags follow the moved value; carry is left alone by a move
  function automatic dtid_ccr_t move_flags(input logic [15:0] v, input logic w,
                                           input dtid_ccr_t old);
    dtid_ccr_t f;
    f   = old;
    f.n = w ? v[15] : v[7];
    f.z = w ? (v == `DTID_REG_RST) : (v[7:0] == `DTID_BYTE_PAD);
    f.v = 1'b0;
    return f;
  endfunction : move_flags

  assign accept  = INSN_VALID_I && INSN_READY_O;
  // Stack push and pop arrive as plain word moves on the stack register
  assign is_move = INSN_I.op == `DTID_OP_MOVE;
  assign legal   = (INSN_I.op < `DTID_OP_COUNT)
                && !(is_move && INSN_I.word && INSN_I.mode == DTID_M_ABS8)
                && !(is_move && INSN_I.store && INSN_I.mode == DTID_M_IMM);
  assign mem_mode = !(INSN_I.mode inside {DTID_M_REG, DTID_M_IMM});
  assign step     = INSN_I.word ? `DTID_STEP_WORD : `DTID_STEP_BYTE;
  assign base     = regs_r[INSN_I.rm];

  always_comb begin
    case (INSN_I.mode)
      DTID_M_DISP:   ea = base + INSN_I.ext;
      DTID_M_PREDEC: ea = base - step;
      DTID_M_ABS8:   ea = {`DTID_SHORT_HI, INSN_I.ext[7:0]};
      DTID_M_ABS16:  ea = INSN_I.ext;
      default:       ea = base;
    endcase
  end

  assign ea_bus   = INSN_I.word ? {ea[15:1], 1'b0} : ea;
  assign load_val = cur_r.word ? MEM_RDATA_I : {regs_r[cur_r.rn][15:8], MEM_RDATA_I[7:0]};

  dtid_cond_eval u_cond (
    .ccr_i   (ccr_r),
    .cc_i    (INSN_I.cc),
    .taken_o (cond_true)
  );

  always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
    if (!NRST_I) begin
      state_r      <= DTID_S_IDLE;
      INSN_READY_O <= 1'b1;
      cur_r        <= '0;
      ptr_r        <= `DTID_REG_RST;
    end else if (state_r == DTID_S_IDLE) begin
      if (accept && legal && is_move && mem_mode) begin
        state_r      <= DTID_S_MEM;
        INSN_READY_O <= 1'b0;
        cur_r        <= INSN_I;
        ptr_r        <= base;
      end
    end else if (MEM_ACK_I) begin
      state_r      <= DTID_S_IDLE;
      INSN_READY_O <= 1'b1;
    end
  end

  // Request stays up until the memory acknowledges it
  always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
    if (!NRST_I) begin
      MEM_REQ_O   <= 1'b0;
      MEM_WE_O    <= 1'b0;
      MEM_BYTE_O  <= 1'b0;
      MEM_ADDR_O  <= `DTID_REG_RST;
      MEM_WDATA_O <= `DTID_REG_RST;
    end else if (accept && legal && is_move && mem_mode) begin
      MEM_REQ_O   <= 1'b1;
      MEM_WE_O    <= INSN_I.store;
      MEM_BYTE_O  <= !INSN_I.word;
      MEM_ADDR_O  <= ea_bus;
      MEM_WDATA_O <= INSN_I.word ? regs_r[INSN_I.rn]
                                 : {`DTID_BYTE_PAD, regs_r[INSN_I.rn][7:0]};
    end else if (state_r == DTID_S_MEM && MEM_ACK_I) begin
      MEM_REQ_O <= 1'b0;
      MEM_WE_O  <= 1'b0;
    end
  end

  // Pointer update is written last so a load into the pointer itself loses
  always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
    if (!NRST_I) begin
      for (int i = 0; i < `DTID_NUM_REGS; i++) begin
        regs_r[i] <= `DTID_REG_RST;
      end
    end else if (state_r == DTID_S_IDLE) begin
      if (accept && legal && is_move) begin
        case (INSN_I.mode)
          DTID_M_REG:    regs_r[INSN_I.rn] <= INSN_I.word ? base
                                           : {regs_r[INSN_I.rn][15:8], base[7:0]};
          DTID_M_IMM:    regs_r[INSN_I.rn] <= INSN_I.word ? INSN_I.ext
                                           : {regs_r[INSN_I.rn][15:8], INSN_I.ext[7:0]};
          DTID_M_PREDEC: regs_r[INSN_I.rm] <= ea;
          default:       ;
        endcase
      end
    end else if (MEM_ACK_I) begin
      if (!cur_r.store) begin
        regs_r[cur_r.rn] <= load_val;
      end
      if (cur_r.mode == DTID_M_POSTINC) begin
        regs_r[cur_r.rm] <= ptr_r + (cur_r.word ? `DTID_STEP_WORD : `DTID_STEP_BYTE);
      end
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
    if (!NRST_I) begin
      ccr_r <= dtid_ccr_t'(`DTID_CCR_RST);
    end else if (state_r == DTID_S_IDLE && accept && legal && is_move) begin
      if (INSN_I.mode == DTID_M_REG) begin
        ccr_r <= move_flags(base, INSN_I.word, ccr_r);
      end else if (INSN_I.mode == DTID_M_IMM) begin
        ccr_r <= move_flags(INSN_I.ext, INSN_I.word, ccr_r);
      end else if (INSN_I.store) begin
        ccr_r <= move_flags(regs_r[INSN_I.rn], INSN_I.word, ccr_r);
      end
    end else if (state_r == DTID_S_MEM && MEM_ACK_I && !cur_r.store) begin
      ccr_r <= move_flags(MEM_RDATA_I, cur_r.word, ccr_r);
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
    if (!NRST_I) begin
      DONE_O         <= 1'b0;
      ILLEGAL_O      <= 1'b0;
      BRANCH_TAKEN_O <= 1'b0;
      GROUP_O        <= DTID_G_TRANSFER;
    end else begin
      DONE_O         <= (accept && !(legal && is_move && mem_mode))
                     || (state_r == DTID_S_MEM && MEM_ACK_I);
      ILLEGAL_O      <= accept && !legal;
      BRANCH_TAKEN_O <= accept && legal && INSN_I.op == `DTID_OP_BCC && cond_true;
      if (accept) begin
        GROUP_O <= group_of(INSN_I.op);
      end
    end
  end

  assign CCR_O = ccr_r;
  assign SP_O  = regs_r[SP_INDEX];

  default clocking @(posedge CLK_SYS_I); endclocking
  default disable iff (!NRST_I);

  logic acc_mv;
  assign acc_mv = accept && legal && is_move;

  property p_op_range;
    accept && INSN_I.op >= `DTID_OP_COUNT |=> ILLEGAL_O && DONE_O;
  endproperty
  a_op_range: assert property (p_op_range) else $error("out of range op not flagged");

  property p_push;
    acc_mv && INSN_I.store && INSN_I.word && INSN_I.mode == DTID_M_PREDEC
      && INSN_I.rm == SP_INDEX
      |=> MEM_REQ_O && MEM_WE_O && MEM_WDATA_O == $past(regs_r[INSN_I.rn])
          && SP_O == $past(SP_O) - `DTID_STEP_WORD && MEM_ADDR_O == {SP_O[15:1], 1'b0};
  endproperty
  a_push: assert property (p_push) else $error("push store wrong");

  property p_pop;
    state_r == DTID_S_MEM && MEM_ACK_I && !cur_r.store && cur_r.word
      && cur_r.mode == DTID_M_POSTINC && cur_r.rm == SP_INDEX
      |=> SP_O == $past(ptr_r) + `DTID_STEP_WORD && INSN_READY_O;
  endproperty
  a_pop: assert property (p_pop) else $error("pop pointer update wrong");

  property p_short_word;
    accept && is_move && INSN_I.word && INSN_I.mode == DTID_M_ABS8 |=> ILLEGAL_O && !MEM_REQ_O;
  endproperty
  a_short_word: assert property (p_short_word) else $error("word short absolute accepted");

  property p_short_addr;
    acc_mv && !INSN_I.word && INSN_I.mode == DTID_M_ABS8
      |=> MEM_REQ_O && MEM_ADDR_O == {`DTID_SHORT_HI, $past(INSN_I.ext[7:0])};
  endproperty
  a_short_addr: assert property (p_short_addr) else $error("short absolute address wrong");

  property p_even_word;
    MEM_REQ_O && !MEM_BYTE_O |-> !MEM_ADDR_O[0];
  endproperty
  a_even_word: assert property (p_even_word) else $error("odd word address on bus");

  property p_predec;
    acc_mv && INSN_I.mode == DTID_M_PREDEC
      |=> regs_r[$past(INSN_I.rm)] == $past(base) - $past(step);
  endproperty
  a_predec: assert property (p_predec) else $error("predecrement step wrong");

  property p_imm_flags;
    acc_mv && INSN_I.word && INSN_I.mode == DTID_M_IMM
      |=> CCR_O.z == ($past(INSN_I.ext) == `DTID_REG_RST) && CCR_O.n == $past(INSN_I.ext[15])
          && !CCR_O.v && DONE_O && regs_r[$past(INSN_I.rn)] == $past(INSN_I.ext);
  endproperty
  a_imm_flags: assert property (p_imm_flags) else $error("immediate move flags wrong");

  property p_branch;
    accept && INSN_I.op == `DTID_OP_BCC |=> BRANCH_TAKEN_O == $past(cond_true);
  endproperty
  a_branch: assert property (p_branch) else $error("branch decision wrong");

  property p_mem_hold;
    MEM_REQ_O && !MEM_ACK_I |=> MEM_REQ_O && !INSN_READY_O && $stable(MEM_ADDR_O);
  endproperty
  a_mem_hold: assert property (p_mem_hold) else $error("request dropped before ack");

  c_push:   cover property (acc_mv && INSN_I.mode == DTID_M_PREDEC && INSN_I.rm == SP_INDEX);
  c_pop:    cover property (state_r == DTID_S_MEM && MEM_ACK_I && cur_r.mode == DTID_M_POSTINC);
  c_branch: cover property (BRANCH_TAKEN_O);
  c_illeg:  cover property (ILLEGAL_O);
endmodule : dtid_top

// *** tb.sv ***
// Self-checking bench for the transfer decode block with a data memory model.
// Assumes dtid_pkg and dtid_defs.svh are compiled first.
`include "dtid_defs.svh"
module tb;
  import dtid_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {logic ill; logic brt; logic gchk; dtid_group_t grp;
                         dtid_ccr_t condition_flag_reg; logic [15:0] sp;} dtid_exp_t;
  typedef struct packed {logic we; logic byt; logic [15:0] addr; logic [15:0] wd;} dtid_req_t;
  logic        clk, nrst, valid, ready, req, we, byt, ack, done, ill, brt, req_seen;
  logic [15:0] addr, wdata, rdata, sp, seed;
  logic [1:0]  lat;
  dtid_insn_t  insn;
  dtid_group_t grp, mg;
  dtid_ccr_t   condition_flag_reg, mc;
  logic [15:0] r [8];
  logic [7:0]  sh [logic [15:0]];
  dtid_exp_t   dq [$];
  dtid_req_t   mq [$];
  int          err_total, total_checks;

  dtid_top i_dtid_top (.CLK_SYS_I(clk), .NRST_I(nrst), .INSN_VALID_I(valid), .INSN_I(insn),
    .INSN_READY_O(ready), .MEM_REQ_O(req), .MEM_WE_O(we), .MEM_BYTE_O(byt),
    .MEM_ADDR_O(addr), .MEM_WDATA_O(wdata), .MEM_ACK_I(ack), .MEM_RDATA_I(rdata),
    .DONE_O(done), .ILLEGAL_O(ill), .BRANCH_TAKEN_O(brt), .GROUP_O(grp), .CCR_O(condition_flag_reg),
    .SP_O(sp));
  dtid_mem_model i_dtid_mem_model (.clk_i(clk), .nrst_i(nrst), .lat_i(lat), .req_i(req),
    .we_i(we), .byte_i(byt), .addr_i(addr), .wdata_i(wdata), .ack_o(ack), .rdata_o(rdata));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  function automatic logic [15:0] rnd();
    seed ^= seed << 7;
    seed ^= seed >> 9;
    seed ^= seed << 8;
    return seed;
  endfunction : rnd
  function automatic logic [7:0] rd(input logic [15:0] a);
    return sh.exists(a) ? sh[a] : 8'h00;
  endfunction : rd
  function automatic dtid_insn_t mk(input logic [5:0] op, input logic [3:0] cc, input logic w,
      input logic s, input dtid_mode_t m, input logic [2:0] rn, input logic [2:0] rm,
      input logic [15:0] x);
    return '{op, cc, w, s, m, rn, rm, x};
  endfunction : mk
  function automatic logic cond(input logic [3:0] cc);
    logic t;
    case (cc[3:1])
      3'h0: t = 1'b1;
      3'h1: t = !(mc.c | mc.z);
      3'h2: t = !mc.c;
      3'h3: t = !mc.z;
      3'h4: t = !mc.v;
      3'h5: t = !mc.n;
      3'h6: t = !(mc.n ^ mc.v);
      default: t = !(mc.z | (mc.n ^ mc.v));
    endcase
    return t ^ cc[0];
  endfunction : cond
  function automatic dtid_group_t grp_of(input logic [5:0] op);
    return op == 0 ? DTID_G_TRANSFER : op < 15 ? DTID_G_ARITH : op < 19 ? DTID_G_LOGIC :
           op < 27 ? DTID_G_SHIFT : op < 41 ? DTID_G_BIT : op < 46 ? DTID_G_BRANCH :
           op < 54 ? DTID_G_SYSTEM : DTID_G_BLOCK;
  endfunction : grp_of
  task automatic wr(input logic [2:0] n, input logic [15:0] v, input logic w);
    if (w) r[n] = v;
    else r[n][7:0] = v[7:0];
    mc.n = w ? v[15] : v[7];
    mc.z = w ? (v == 16'h0) : (v[7:0] == 8'h0);
    mc.v = 1'b0;
  endtask : wr

  task automatic issue(input dtid_insn_t i);
    logic [15:0] a, v, p, st, t;
    dtid_exp_t e;
    st = i.word ? `DTID_STEP_WORD : `DTID_STEP_BYTE;
    p = r[i.rm];
    e.ill = i.op >= 55 || (i.op == 0 && ((i.word && i.mode == DTID_M_ABS8)
                                      || (i.store && i.mode == DTID_M_IMM)));
    e.gchk = !e.ill;
    e.brt = !e.ill && i.op == 41 && cond(i.cc);
    if (!e.ill) mg = grp_of(i.op);
    if (!e.ill && i.op == 0) begin
      if (i.mode == DTID_M_REG) wr(i.rn, p, i.word);
      else if (i.mode == DTID_M_IMM) wr(i.rn, i.ext, i.word);
      else begin
        a = i.mode == DTID_M_ABS8 ? {`DTID_SHORT_HI, i.ext[7:0]} :
            i.mode == DTID_M_ABS16 ? i.ext : i.mode == DTID_M_DISP ? p + i.ext :
            i.mode == DTID_M_PREDEC ? p - st : p;
        if (i.mode == DTID_M_PREDEC) r[i.rm] = a;
        if (i.word) a[0] = 1'b0;
        v = r[i.rn];
        if (i.store && i.word) sh[a] = v[15:8];
        if (i.store) sh[i.word ? a + 16'h1 : a] = v[7:0];
        if (!i.store) v = i.word ? {rd(a), rd(a + 16'h1)} : {8'h00, rd(a)};
        mq.push_back('{i.store, !i.word, a, i.word ? v : {8'h00, v[7:0]}});
        wr(i.store ? i.rm : i.rn, i.store ? r[i.rm] : v, i.store || i.word);
        if (i.store) wr(i.rn, v, i.word);
        if (i.mode == DTID_M_POSTINC) r[i.rm] = p + st;
      end
    end
    e.grp = mg;
    e.condition_flag_reg = mc;
    e.sp = r[7];
    dq.push_back(e);
    t = rnd();
    insn = i;
    valid = 1'b1;
    lat = t[1:0];
    // Ready is judged off the edge, so the edge that follows is the taking one
    while (ready !== 1'b1) begin
      @(posedge clk);
      #1;
    end
    @(posedge clk);
    #1;
  endtask : issue

  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic cmp_done(input dtid_exp_t e);
    chk("illegal", e.ill, ill);
    chk("branch", e.brt, brt);
    if (e.gchk) chk("group", e.grp, grp);
    chk("flags", e.condition_flag_reg, condition_flag_reg);
    chk("sp", e.sp, sp);
  endtask : cmp_done
  task automatic cmp_mem(input dtid_req_t m);
    chk("we", m.we, we);
    chk("byte", m.byt, byt);
    chk("addr", m.addr, addr);
    if (m.we) chk("wdata", m.wd, wdata);
  endtask : cmp_mem

  always @(negedge clk) begin
    if (nrst && done === 1'b1 && dq.size() > 0) cmp_done(dq.pop_front());
    else if (nrst && done === 1'b1) chk("done", 16'h0, 16'h1);
    if (nrst && req === 1'b1 && !req_seen && mq.size() > 0) cmp_mem(mq.pop_front());
    req_seen = (req === 1'b1);
  end

  task automatic results();
    if (err_total == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : results

  initial begin
    #(50 * 20000);
    err_total++;
    results();
  end

  initial begin
    dtid_insn_t  i;
    logic [15:0] t;
    nrst = 1'b0;
    valid = 1'b0;
    insn = '0;
    lat = 2'h0;
    seed = 16'h0028;
    err_total = 0;
    total_checks = 0;
    req_seen = 1'b0;
    mc = `DTID_CCR_RST;
    mg = DTID_G_TRANSFER;
    for (int k = 0; k < 8; k++) r[k] = `DTID_REG_RST;
    repeat (16) @(posedge clk);
    #1;
    nrst = 1'b1;
    for (int k = 0; k < 8; k++) issue(mk(0, 0, 1, 0, DTID_M_IMM, k, 0, rnd() & 16'hfffe));
    // Byte load keeps the upper byte, seen through the following word store
    issue(mk(0, 0, 0, 0, DTID_M_IMM, 1, 0, 16'h0080));
    issue(mk(0, 0, 1, 1, DTID_M_IND, 1, 2, 16'h0));
    for (int k = 1; k < 64; k++) begin
      t = rnd();
      issue(mk(k, t[3:0], 1, 0, DTID_M_REG, 0, 0, 16'h0));
    end
    foreach (r[k]) begin
      issue(mk(0, 0, 1, 0, DTID_M_IMM, 0, 0, {k[1], 14'h0, k[0]}));
      for (int c = 0; c < 16; c++) issue(mk(41, c, 1, 0, DTID_M_REG, 0, 0, 16'h0));
    end
    issue(mk(0, 0, 1, 0, DTID_M_ABS8, 3, 0, 16'h0012));
    issue(mk(0, 0, 1, 1, DTID_M_IMM, 3, 0, 16'h0012));
    issue(mk(0, 0, 0, 1, DTID_M_ABS8, 3, 0, 16'h1234));
    issue(mk(0, 0, 0, 0, DTID_M_ABS8, 4, 0, 16'h5634));
    issue(mk(0, 0, 1, 1, DTID_M_PREDEC, 2, 7, 16'h0));
    issue(mk(0, 0, 1, 0, DTID_M_POSTINC, 5, 7, 16'h0));
    issue(mk(0, 0, 1, 0, DTID_M_POSTINC, 7, 7, 16'h0));
    issue(mk(0, 0, 1, 0, DTID_M_IMM, 3, 0, 16'h4001));
    issue(mk(0, 0, 1, 1, DTID_M_IND, 6, 3, 16'h0));
    issue(mk(0, 0, 0, 0, DTID_M_POSTINC, 1, 3, 16'h0));
    issue(mk(0, 0, 0, 1, DTID_M_PREDEC, 1, 3, 16'h0));
    // Drain, then reset in mid-run; the model restarts from the reset state
    valid = 1'b0;
    repeat (8) @(posedge clk);
    #1;
    if (dq.size() != 0 || mq.size() != 0) err_total++;
    nrst = 1'b0;
    mc = `DTID_CCR_RST;
    mg = DTID_G_TRANSFER;
    for (int k = 0; k < 8; k++) r[k] = `DTID_REG_RST;
    repeat (2) @(posedge clk);
    #1;
    chk("sp", `DTID_REG_RST, sp);
    chk("flags", 16'h0000, {12'h000, condition_flag_reg});
    nrst = 1'b1;
    for (int k = 0; k < 300; k++) begin
      t = rnd();
      i = mk(0, 0, t[0], t[1], dtid_mode_t'(t[4:2]), t[7:5], t[10:8], rnd());
      if (i.word && i.mode == DTID_M_ABS8) i.mode = DTID_M_ABS16;
      if (i.store && i.mode == DTID_M_IMM) i.store = 1'b0;
      if (i.rm == 3'h7 && i.mode inside {DTID_M_POSTINC, DTID_M_PREDEC}) i.word = 1'b1;
      if (i.mode == DTID_M_PREDEC && i.rn == i.rm) i.rn = ~i.rm;
      issue(i);
    end
    valid = 1'b0;
    repeat (20) @(posedge clk);
    if (dq.size() != 0 || mq.size() != 0) err_total++;
    results();
  end
endmodule : tb
